// >>> rtl/status_flags_params.svh
`ifndef STATUS_FLAGS_PARAMS_SVH
`define STATUS_FLAGS_PARAMS_SVH

`define STAT_WIDTH        8
`define STAT_RESET        8'h00
`define BIT_OUT_FULL      0
`define BIT_IN_FULL       1
`define BIT_USER_TWO      2
`define BIT_CMD_DATA      3
`define BIT_USER_LO       4
`define BIT_USER_HI       7
`define HOST_ADDR_CMD_BIT 2
`define USER_MASK         8'hF4

`endif

// >>> rtl/status_flags_pkg.sv
package status_flags_pkg;

  // One access from the slave processor side, valid for a single cycle.
  typedef struct packed {
    logic       status_wr;
    logic [7:0] status_wdata;
    logic       out_data_wr;
    logic       in_data_rd;
  } slave_access_t;

  // One completed LPC I/O cycle from the host side, valid for a single cycle.
  typedef struct packed {
    logic       in_data_wr;
    logic [2:0] io_addr_low;
    logic       out_data_rd;
    logic       status_rd;
    logic       status_wr;
  } host_access_t;

endpackage : status_flags_pkg

// >>> rtl/host_channel3_status.sv
// How it works
// - Layout valid when two-way off, select on.
// - Bits 7..4 and 2 slave read/write bits.
// - Host data write copies address bit 2.
// - Host inbound data write sets inbound-full.
// - Slave inbound data read clears inbound-full.
// - Inbound-full drives slave interrupt request.
// - Slave outbound data write sets outbound-full.
// - Host read or slave zero clears outbound-full.
// - Slave writing one leaves outbound-full unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_params.svh"

module host_channel3_status
  import status_flags_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   two_way_reg_enable,
  input  wire logic                   status_layout_select,
  input  wire slave_access_t          slave_acc,
  input  wire host_access_t           host_acc,
  output logic [`STAT_WIDTH-1:0]      slave_rdata,
  output logic [`STAT_WIDTH-1:0]      host_rdata,
  output logic                        layout_active,
  output logic                        inbound_irq
);

  logic [`STAT_WIDTH-1:0] stat_reg;
  logic [`STAT_WIDTH-1:0] stat_next;
  logic [`STAT_WIDTH-1:0] host_rdata_reg;
  logic [`STAT_WIDTH-1:0] host_rdata_next;
  logic                   out_zero_wr;
  logic                   out_clear;

  // ----------------------------------------------------------------
  // Flag helper
  // ----------------------------------------------------------------
  // Both handshake flags settle a set and a clear in one cycle the same way.
  // The set wins, so a byte that arrives just as the old one is consumed is
  // never reported as already taken; the price is that the clearing side may
  // see the flag still up and has to look at it again.
  function automatic logic next_flag(
    input logic cur,
    input logic set_ev,
    input logic clr_ev
  );
    logic result;
    result = cur;
    if (clr_ev) begin
      result = 1'b0;
    end
    if (set_ev) begin
      result = 1'b1;
    end
    return result;
  endfunction : next_flag

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // A slave status write clears the outbound flag only through a zero in bit 0.
  // A one there is ignored, so firmware may write back what it has just read.
  assign out_zero_wr = slave_acc.status_wr &&
                       !slave_acc.status_wdata[`BIT_OUT_FULL];
  assign out_clear   = host_acc.out_data_rd || out_zero_wr;

  // The command indicator follows every host data write, data or command alike.
  always_comb begin
    stat_next = stat_reg;
    if (slave_acc.status_wr) begin
      stat_next = (stat_reg & ~`USER_MASK) | (slave_acc.status_wdata & `USER_MASK);
    end
    stat_next[`BIT_OUT_FULL] = next_flag(stat_reg[`BIT_OUT_FULL],
                                         slave_acc.out_data_wr,
                                         out_clear);
    stat_next[`BIT_IN_FULL]  = next_flag(stat_reg[`BIT_IN_FULL],
                                         host_acc.in_data_wr,
                                         slave_acc.in_data_rd);
    if (host_acc.in_data_wr) begin
      stat_next[`BIT_CMD_DATA] = host_acc.io_addr_low[`HOST_ADDR_CMD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_reg <= `STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign slave_rdata = stat_reg;
  assign inbound_irq = stat_reg[`BIT_IN_FULL];

  // ----------------------------------------------------------------
  // Inbound side checks
  // ----------------------------------------------------------------
  // A check that names a clearing event excludes a same-cycle set, since the
  // set wins there by design.
  chk_in_full_set: assert property (@(posedge clk) disable iff (reset)
    host_acc.in_data_wr |=> stat_reg[`BIT_IN_FULL])
    else $error("Inbound-full not set by host write.");

  chk_in_full_clr: assert property (@(posedge clk) disable iff (reset)
    slave_acc.in_data_rd && !host_acc.in_data_wr |=> !stat_reg[`BIT_IN_FULL])
    else $error("Inbound-full not cleared by slave read.");

  chk_in_full_hold: assert property (@(posedge clk) disable iff (reset)
    !host_acc.in_data_wr && !slave_acc.in_data_rd |=> $stable(stat_reg[`BIT_IN_FULL]))
    else $error("Inbound-full changed with no event.");

  chk_irq_follow: assert property (@(posedge clk) disable iff (reset)
    host_acc.in_data_wr ##1 !slave_acc.in_data_rd |=> inbound_irq)
    else $error("Interrupt request lost.");

  chk_irq_clear: assert property (@(posedge clk) disable iff (reset)
    slave_acc.in_data_rd && !host_acc.in_data_wr |=> !inbound_irq)
    else $error("Interrupt request not withdrawn.");

  chk_cmd_copy: assert property (@(posedge clk) disable iff (reset)
    host_acc.in_data_wr |=>
      stat_reg[`BIT_CMD_DATA] == $past(host_acc.io_addr_low[`HOST_ADDR_CMD_BIT]))
    else $error("Command indicator does not follow address bit.");

  chk_cmd_hold: assert property (@(posedge clk) disable iff (reset)
    !host_acc.in_data_wr |=> $stable(stat_reg[`BIT_CMD_DATA]))
    else $error("Command indicator changed with no host write.");

  chk_slave_ro_bits: assert property (@(posedge clk) disable iff (reset)
    slave_acc.status_wr && !slave_acc.in_data_rd && !host_acc.in_data_wr
      |=> stat_reg[`BIT_IN_FULL] == $past(stat_reg[`BIT_IN_FULL]) &&
          stat_reg[`BIT_CMD_DATA] == $past(stat_reg[`BIT_CMD_DATA]))
    else $error("Slave write reached a read-only bit.");

  // ----------------------------------------------------------------
  // Outbound side checks
  // ----------------------------------------------------------------
  chk_out_full_set: assert property (@(posedge clk) disable iff (reset)
    slave_acc.out_data_wr |=> stat_reg[`BIT_OUT_FULL])
    else $error("Outbound-full not set by slave write.");

  chk_out_full_clr: assert property (@(posedge clk) disable iff (reset)
    host_acc.out_data_rd && !slave_acc.out_data_wr |=> !stat_reg[`BIT_OUT_FULL])
    else $error("Outbound-full not cleared by host read.");

  chk_out_zero_clr: assert property (@(posedge clk) disable iff (reset)
    slave_acc.status_wr && !slave_acc.status_wdata[`BIT_OUT_FULL] && !slave_acc.out_data_wr
      |=> !stat_reg[`BIT_OUT_FULL])
    else $error("Outbound-full not cleared by slave zero write.");

  chk_out_one_hold: assert property (@(posedge clk) disable iff (reset)
    slave_acc.status_wr && slave_acc.status_wdata[`BIT_OUT_FULL] &&
    !slave_acc.out_data_wr && !host_acc.out_data_rd
      |=> stat_reg[`BIT_OUT_FULL] == $past(stat_reg[`BIT_OUT_FULL]))
    else $error("Slave write of one altered outbound-full.");

  chk_out_full_hold: assert property (@(posedge clk) disable iff (reset)
    !slave_acc.out_data_wr && !host_acc.out_data_rd &&
    !(slave_acc.status_wr && !slave_acc.status_wdata[`BIT_OUT_FULL])
      |=> $stable(stat_reg[`BIT_OUT_FULL]))
    else $error("Outbound-full changed with no event.");

  // ----------------------------------------------------------------
  // User bit checks
  // ----------------------------------------------------------------
  chk_user_bits: assert property (@(posedge clk) disable iff (reset)
    slave_acc.status_wr |=>
      (stat_reg & `USER_MASK) == ($past(slave_acc.status_wdata) & `USER_MASK))
    else $error("User bits not written.");

  chk_user_hold: assert property (@(posedge clk) disable iff (reset)
    !slave_acc.status_wr |=> $stable(stat_reg & `USER_MASK))
    else $error("User bits changed with no slave write.");

  // ----------------------------------------------------------------
  // Host read data
  // ----------------------------------------------------------------
  // Host status writes are simply not decoded here, so they change nothing.
  // The read value is captured once per read and then held, so the host sees
  // one consistent byte even if a flag moves while its cycle completes.
  always_comb begin
    host_rdata_next = host_rdata_reg;
    if (host_acc.status_rd) begin
      host_rdata_next = stat_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      host_rdata_reg <= `STAT_RESET;
    end else begin
      host_rdata_reg <= host_rdata_next;
    end
  end

  assign host_rdata = host_rdata_reg;

  chk_host_read: assert property (@(posedge clk) disable iff (reset)
    host_acc.status_rd |=> host_rdata == $past(stat_reg))
    else $error("Host read data wrong.");

  chk_host_rd_hold: assert property (@(posedge clk) disable iff (reset)
    !host_acc.status_rd |=> $stable(host_rdata))
    else $error("Host read data moved with no status read.");

  chk_host_wr_none: assert property (@(posedge clk) disable iff (reset)
    host_acc.status_wr && !host_acc.in_data_wr && !host_acc.out_data_rd &&
    (slave_acc == '0) |=> $stable(stat_reg))
    else $error("Host status write changed a bit.");

  // ----------------------------------------------------------------
  // Layout decode
  // ----------------------------------------------------------------
  // The flag only reports whether this bit layout is the one in force; the
  // register behaves the same either way, and the mode selects themselves
  // belong to the surrounding interface.
  assign layout_active = !two_way_reg_enable && status_layout_select;

endmodule : host_channel3_status
`default_nettype wire

// >>> sim/lpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model
  import status_flags_pkg::*;
(
  input  wire logic   clk,
  output var host_access_t host_acc
);
  initial host_acc = '0;
  // A finished LPC I/O cycle is a single-cycle pulse; an idle cycle follows each one.
  task automatic io(input host_access_t a);
    @(negedge clk) host_acc = a;
    @(negedge clk) host_acc = '0;
  endtask : io
endmodule : lpc_host_model
`default_nettype wire

// >>> sim/host_channel3_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_channel3_status_tb
  import status_flags_pkg::*;
;
  logic          clk, reset, two_way_reg_enable, status_layout_select, layout_active, inbound_irq;
  logic [7:0]    slave_rdata, host_rdata;
  slave_access_t slave_acc;
  host_access_t  host_acc;
  int            error_cnt = 0;
  int            checked = 0;
  host_channel3_status uut (.clk(clk), .reset(reset), .two_way_reg_enable(two_way_reg_enable),
    .status_layout_select(status_layout_select), .slave_acc(slave_acc), .host_acc(host_acc),
    .slave_rdata(slave_rdata), .host_rdata(host_rdata), .layout_active(layout_active),
    .inbound_irq(inbound_irq));
  lpc_host_model host (.clk(clk), .host_acc(host_acc));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic sl(input slave_access_t a);
    @(negedge clk) slave_acc = a;
    @(negedge clk) slave_acc = '0;
  endtask : sl
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_lay;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) {two_way_reg_enable, status_layout_select} = 2'(i);
      #1 chk("layout", {7'h00, layout_active}, {7'h00, i == 1});
    end
    $display("layout done");
  endtask : t_lay
  task automatic t_in;
    host.io('{1'b1, 3'h4, 1'b0, 1'b0, 1'b0});
    chk("stat", slave_rdata, 8'h0A);
    chk("irq", {7'h00, inbound_irq}, 8'h01);
    sl('{1'b0, 8'h00, 1'b0, 1'b1});
    chk("stat", slave_rdata, 8'h08);
    host.io('{1'b1, 3'h3, 1'b0, 1'b0, 1'b0});
    chk("stat", slave_rdata, 8'h02);
    sl('{1'b1, 8'h0A, 1'b0, 1'b1});
    chk("stat", slave_rdata, 8'h00);
    $display("inbound done");
  endtask : t_in
  task automatic t_out;
    sl('{1'b0, 8'h00, 1'b1, 1'b0});
    chk("stat", slave_rdata, 8'h01);
    sl('{1'b1, 8'hFF, 1'b0, 1'b0});
    chk("stat", slave_rdata, 8'hF5);
    host.io('{1'b0, 3'h0, 1'b0, 1'b1, 1'b1});
    chk("host", host_rdata, 8'hF5);
    chk("stat", slave_rdata, 8'hF5);
    host.io('{1'b0, 3'h0, 1'b1, 1'b0, 1'b0});
    chk("stat", slave_rdata, 8'hF4);
    sl('{1'b0, 8'h00, 1'b1, 1'b0});
    sl('{1'b1, 8'h00, 1'b0, 1'b0});
    chk("stat", slave_rdata, 8'h00);
    $display("outbound done");
  endtask : t_out
  task automatic t_race;
    fork
      host.io('{1'b0, 3'h0, 1'b1, 1'b0, 1'b0});
      sl('{1'b0, 8'h00, 1'b1, 1'b0});
    join
    chk("stat", slave_rdata, 8'h01);
    fork
      host.io('{1'b1, 3'h0, 1'b0, 1'b0, 1'b0});
      sl('{1'b1, 8'h00, 1'b1, 1'b1});
    join
    chk("stat", slave_rdata, 8'h03);
    host.io('{1'b0, 3'h4, 1'b0, 1'b0, 1'b1});
    chk("stat", slave_rdata, 8'h03);
    chk("host", host_rdata, 8'hF5);
    $display("race done");
  endtask : t_race
  task automatic t_rst;
    @(negedge clk) reset = 1'b1;
    @(negedge clk) reset = 1'b0;
    chk("reset", slave_rdata, 8'h00);
    chk("reset", host_rdata, 8'h00);
    chk("irq", {7'h00, inbound_irq}, 8'h00);
    host.io('{1'b1, 3'h4, 1'b0, 1'b0, 1'b0});
    chk("stat", slave_rdata, 8'h0A);
    $display("reset done");
  endtask : t_rst
  initial begin
    reset = 1'b1;
    two_way_reg_enable = 1'b0;
    status_layout_select = 1'b1;
    slave_acc = '0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    chk("reset", slave_rdata, 8'h00);
    chk("reset", host_rdata, 8'h00);
    t_lay();
    t_in();
    t_out();
    t_race();
    t_rst();
    close_out();
  end
endmodule : host_channel3_status_tb
`default_nettype wire
